// file: tb/ctl_model.sv
// Controller model driving the control port
`timescale 1ns/1ns
module ctl_model (
  input wire logic clk_i,
  input wire logic [31:0] readdata_i,
  output logic cs_o,
  output logic wr_o,
  output logic [3:0] addr_o,
  output logic [31:0] wd_o
);
  initial begin
    cs_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 4'h0;
    wd_o = 32'h0;
  end
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] di, output logic [31:0] d);
    cs_o = 1'b1;
    wr_o = w;
    addr_o = a;
    wd_o = di;
    // Reads hold for both wait states, writes for one edge
    if (!w) begin
      repeat (2) @(negedge clk_i);
    end
    d = readdata_i;
    @(negedge clk_i);
    cs_o = 1'b0;
    addr_o = ~addr_o;
    wd_o = ~wd_o;
    @(negedge clk_i);
  endtask : acc
endmodule : ctl_model

// file: tb/frame_run_control_port_monitor.sv
// Port checker for the frame run control port
`timescale 1ns/1ns
module frame_run_control_port_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic chipselect_i,
  input wire logic write_i,
  input wire logic [3:0] address_i,
  input wire logic [31:0] writedata_i,
  input wire logic [31:0] readdata_o,
  input wire logic frame_ready_i,
  input wire logic frame_end_i,
  input wire logic frame_start_ok_o,
  input wire logic running_o,
  input wire logic settings_load_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  start_runs_a: assert property (frame_start_ok_o && frame_ready_i |=> running_o) else $error("no run");
  idle_holds_a: assert property (!running_o && !(frame_start_ok_o && frame_ready_i) |=> !running_o) else $error("run");
  load_start_a: assert property (!running_o && frame_start_ok_o && frame_ready_i |=> settings_load_o) else $error("ld");
  load_pulse_a: assert property (settings_load_o |-> $past(frame_start_ok_o && frame_ready_i)
    && running_o ##1 !settings_load_o) else $error("lp");
  unmapped_zero_a: assert property (chipselect_i && !write_i && address_i > 1 |-> ##2 readdata_o == '0) else $error("um");
  write_at_once_a: assert property (chipselect_i && write_i && address_i == 0 && writedata_i[0]
    && !running_o && !frame_start_ok_o |=> frame_start_ok_o) else $error("wr");
  clear_stops_a: assert property (chipselect_i && write_i && address_i == 0 && !writedata_i[0] |=> !frame_start_ok_o) else $error("cl");
  status_write_a: assert property (chipselect_i && write_i && address_i == 1 && !running_o
    && !frame_start_ok_o |=> !frame_start_ok_o) else $error("st");
endmodule : frame_run_control_port_monitor
bind frame_run_control_port frame_run_control_port_monitor mon (.*);

// file: tb/frame_run_control_port_tb.sv
// Self-checking bench for the frame run control port
`timescale 1ns/1ns
module frame_run_control_port_tb;
  logic clk_i, rst_n_i, cs, wr, fr, fe, ok, run, ld;
  logic [3:0] addr;
  logic [31:0] wd, rdat, d;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  frame_run_control_port DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .chipselect_i(cs), .write_i(wr), .address_i(addr),
    .writedata_i(wd), .readdata_o(rdat), .frame_ready_i(fr), .frame_end_i(fe), .frame_start_ok_o(ok),
    .running_o(run), .settings_load_o(ld));
  ctl_model ctl (.clk_i(clk_i), .readdata_i(rdat), .cs_o(cs), .wr_o(wr), .addr_o(addr), .wd_o(wd));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic close_out;
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    rst_n_i = 1'b0;
    fr = 1'b0;
    fe = 1'b0;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("ok", 32'h0, ok);
    fr = 1'b1;
    ctl.acc(1'b0, 4'h0, 32'h0, d);
    chk("run_req", 32'h0, d);
    chk("running", 32'h0, run);
    ctl.acc(1'b1, 4'h1, 32'h1, d);
    ctl.acc(1'b0, 4'h1, 32'h0, d);
    chk("state", 32'h0, d);
    ctl.acc(1'b0, 4'h5, 32'h0, d);
    chk("unmapped", 32'h0, d);
    ctl.acc(1'b1, 4'h0, 32'hffff_ffff, d);
    chk("load", 32'h1, ld);
    chk("running", 32'h1, run);
    ctl.acc(1'b0, 4'h0, 32'h0, d);
    chk("run_req", 32'h1, d);
    ctl.acc(1'b1, 4'h0, 32'h0, d);
    ctl.acc(1'b0, 4'h1, 32'h0, d);
    chk("state", 32'h1, d);
    fe = 1'b1;
    @(negedge clk_i);
    fe = 1'b0;
    chk("running", 32'h0, run);
    ctl.acc(1'b0, 4'h1, 32'h0, d);
    chk("state", 32'h0, d);
    ctl.acc(1'b1, 4'h0, 32'h1, d);
    chk("load", 32'h1, ld);
    // Cleared and set again inside one frame: the next start must still load
    ctl.acc(1'b1, 4'h0, 32'h0, d);
    ctl.acc(1'b1, 4'h0, 32'h1, d);
    fe = 1'b1;
    @(negedge clk_i);
    fe = 1'b0;
    chk("running", 32'h1, run);
    @(negedge clk_i);
    chk("load", 32'h1, ld);
    // Second reset mid-frame; a request written at once is cleared by the core
    rst_n_i = 1'b0;
    fr = 1'b0;
    @(negedge clk_i);
    chk("running", 32'h0, run);
    rst_n_i = 1'b1;
    ctl.acc(1'b1, 4'h0, 32'h1, d);
    chk("ok", 32'h1, ok);
    repeat (2) @(negedge clk_i);
    chk("ok", 32'h0, ok);
    ctl.acc(1'b0, 4'h0, 32'h0, d);
    chk("run_req", 32'h0, d);
    close_out;
  end
endmodule : frame_run_control_port_tb

// file: verilog/frame_run_control_port.sv
// Run request / running status control slave with frame-boundary gating
`timescale 1ns/1ns
module frame_run_control_port #(
  parameter int unsigned ADDR_W = run_ctrl_pkg::ADDR_W_DEF,
  parameter int unsigned DATA_W = run_ctrl_pkg::DATA_W_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control slave port
  input wire logic chipselect_i,
  input wire logic write_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic [DATA_W-1:0] writedata_i,
  output logic [DATA_W-1:0] readdata_o,
  // Processing core side
  input wire logic frame_ready_i,
  input wire logic frame_end_i,
  output logic frame_start_ok_o,
  output logic running_o,
  output logic settings_load_o
);
  localparam logic [ADDR_W-1:0] RUN_ADDR = ADDR_W'(run_ctrl_pkg::RUN_REQUEST_OFS);
  localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'(run_ctrl_pkg::RUNNING_STATE_OFS);

  // Register bank state
  logic run_q;
  logic run_d;
  logic clear_pulse;
  logic wr_run;
  logic rd_access;
  logic [DATA_W-1:0] read_mux;
  logic [DATA_W-1:0] read_now;

  // Frame sequencing state
  run_ctrl_pkg::frame_state_t state_q;
  run_ctrl_pkg::frame_state_t state_d;
  logic start_accept;

  // Settings load state
  logic pending_q;
  logic pending_d;
  logic load_q;
  logic load_d;

  // Self-clear of the run flag after reset release
  settle_timer #(
    .DELAY(run_ctrl_pkg::CLEAR_DELAY_CYCLES)
  ) u_settle (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .fire_o(clear_pulse)
  );

  // Writes take effect in the presenting cycle
  assign wr_run = chipselect_i && write_i && (address_i == RUN_ADDR);
  assign rd_access = chipselect_i && !write_i;

  always_comb begin
    run_d = run_q;
    // A software write in the clear cycle wins so no request is lost
    if (clear_pulse) begin
      run_d = 1'b0;
    end
    if (wr_run) begin
      run_d = writedata_i[run_ctrl_pkg::FLAG_BIT];
    end
  end

  // Status and unmapped locations take no writes; unmapped reads give zero
  always_comb begin
    read_mux = '0;
    unique case (address_i)
      RUN_ADDR: read_mux[run_ctrl_pkg::FLAG_BIT] = run_q;
      STAT_ADDR: read_mux[run_ctrl_pkg::FLAG_BIT] = (state_q != run_ctrl_pkg::ST_HALTED);
      default: read_mux = '0;
    endcase
  end

  // Idle bus holds zero so stale data never leaks into a later read
  assign read_now = rd_access ? read_mux : '0;

  read_delay #(
    .WIDTH(DATA_W),
    .DEPTH(run_ctrl_pkg::READ_WAIT_STATES)
  ) u_rdly (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .data_i(read_now),
    .data_o(readdata_o)
  );

  // Frame may start whenever the core is not inside a frame and run is set
  assign frame_start_ok_o = run_q && (state_q != run_ctrl_pkg::ST_IN_FRAME);
  assign start_accept = frame_start_ok_o && frame_ready_i;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      run_ctrl_pkg::ST_HALTED: begin
        if (start_accept) begin
          state_d = run_ctrl_pkg::ST_IN_FRAME;
        end
      end
      run_ctrl_pkg::ST_IN_FRAME: begin
        // Run request is only looked at on the frame boundary
        if (frame_end_i) begin
          state_d = run_q ? run_ctrl_pkg::ST_BETWEEN : run_ctrl_pkg::ST_HALTED;
        end
      end
      run_ctrl_pkg::ST_BETWEEN: begin
        if (!run_q) begin
          state_d = run_ctrl_pkg::ST_HALTED;
        end else if (start_accept) begin
          state_d = run_ctrl_pkg::ST_IN_FRAME;
        end
      end
    endcase
  end

  // A fresh run request arms exactly one load for the next frame start
  always_comb begin
    pending_d = pending_q;
    load_d = 1'b0;
    if (start_accept && pending_q) begin
      pending_d = 1'b0;
      load_d = 1'b1;
    end
    // Rearming mid-frame matters: the restart may then come from between frames
    if (wr_run && writedata_i[run_ctrl_pkg::FLAG_BIT] && !run_q) begin
      pending_d = 1'b1;
    end
  end

  // Single clock, single asynchronous reset for every flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= run_ctrl_pkg::RUN_REQUEST_RST;
    end else begin
      run_q <= run_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= run_ctrl_pkg::ST_HALTED;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
      load_q <= load_d;
    end
  end

  assign running_o = (state_q != run_ctrl_pkg::ST_HALTED);
  assign settings_load_o = load_q;
endmodule : frame_run_control_port

// file: verilog/read_delay.sv
// Registered delay line that gives read data its fixed wait states
`timescale 1ns/1ns
module read_delay #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] data_o
);
  logic [WIDTH-1:0] stage_q [DEPTH];
  logic [WIDTH-1:0] stage_d [DEPTH];

  always_comb begin
    stage_d[0] = data_i;
    for (int i = 1; i < DEPTH; i++) begin
      stage_d[i] = stage_q[i-1];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_q[i] <= stage_d[i];
      end
    end
  end

  assign data_o = stage_q[DEPTH-1];
endmodule : read_delay

// file: verilog/run_ctrl_pkg.sv
// Shared constants for the frame run control port
package run_ctrl_pkg;
  // Register locations (word index on the control port)
  localparam int unsigned RUN_REQUEST_OFS = 0;
  localparam int unsigned RUNNING_STATE_OFS = 1;
  // Flag position inside each register
  localparam int unsigned FLAG_BIT = 0;
  // Documented port widths vary per core; these are the defaults
  localparam int unsigned ADDR_W_DEF = 4;
  localparam int unsigned DATA_W_DEF = 32;
  // Cycles after reset release before the core clears the run flag
  localparam int unsigned CLEAR_DELAY_CYCLES = 3;
  // Read wait states on the control port
  localparam int unsigned READ_WAIT_STATES = 2;
  // Write wait states, not referenced by the port or the bench
  localparam int unsigned WRITE_WAIT_STATES = 0;
  // Reset value of the run flag before the core clears it itself
  localparam logic RUN_REQUEST_RST = 1'b0;
  // Frame sequencing states
  typedef enum logic [1:0] {
    ST_HALTED,
    ST_IN_FRAME,
    ST_BETWEEN
  } frame_state_t;
endpackage : run_ctrl_pkg

// file: verilog/settle_timer.sv
// One-shot pulse a fixed number of cycles after reset release
`timescale 1ns/1ns
module settle_timer #(
  parameter int unsigned DELAY = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic fire_o
);
  localparam int unsigned CNT_W = $clog2(DELAY + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic fire_q;
  logic fire_d;

  always_comb begin
    count_d = count_q;
    fire_d = 1'b0;
    if (count_q != LAST) begin
      count_d = count_q + CNT_W'(1);
      fire_d = (count_d == LAST);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
      fire_q <= 1'b0;
    end else begin
      count_q <= count_d;
      fire_q <= fire_d;
    end
  end

  assign fire_o = fire_q;
endmodule : settle_timer
